// File: serial_params.svh
// Register offsets, field positions, reset values and timing counts for the serial interface.
`ifndef SERIAL_PARAMS_SVH
`define SERIAL_PARAMS_SVH
`define OFF_MODE_CTRL    12'h000
`define OFF_BUS_STATUS   12'h004
`define OFF_DATA         12'h008
`define OFF_OWN_ADDR     12'h00C
`define OFF_TIMEOUT_CTRL 12'h010
`define OFF_SPI_CTRL_TWO 12'h014
`define MODE_CTRL_RESET  8'hE0
`define MODE_CTRL_MASK   8'hEF
`define BUS_STATUS_RESET 8'h81
`define BUS_STATUS_WMASK 8'h1E
`define SPI_CTRL_RESET   8'h00
`define MODE_MSB         7
`define MODE_LSB         5
`define DEB_MSB          3
`define DEB_LSB          2
`define BIT_MOD_EN       1
`define BIT_INCOMPLETE   0
`define BIT_POLARITY     5
`define BIT_EDGE         4
`define BIT_ORDER        3
`define BIT_SEL_EN       2
`define BIT_WRITE_COLLISION_FLAG         1
`define BIT_TRF          0
`define HALF_DIV4        8'h01
`define HALF_DIV16       8'h07
`define HALF_DIV64       8'h1F
`define BITS_PER_BYTE    4'h8
`define DEB_TWO          3'h2
`define DEB_FOUR         3'h4
`endif

// File: serial_pkg.sv
// Types shared by the serial interface files.
package serial_pkg;
  typedef enum logic [2:0] {
    MODE_M_DIV4   = 3'b000,
    MODE_M_DIV16  = 3'b001,
    MODE_M_DIV64  = 3'b010,
    MODE_M_SUB    = 3'b011,
    MODE_M_TIMER  = 3'b100,
    MODE_SPI_SLV  = 3'b101,
    MODE_I2C_SLV  = 3'b110,
    MODE_UNUSED   = 3'b111
  } op_mode_t;

  typedef enum logic [1:0] {
    XFER_IDLE   = 2'b00,
    XFER_ACTIVE = 2'b01,
    XFER_DONE   = 2'b10
  } xfer_state_t;

  // Pin drive set for one two-way or open-drain line.
  typedef struct packed {
    logic o;
    logic oe;
  } pin_drive_t;

  // Pins of the four-wire bus and the two-wire bus, as driven by the block.
  typedef struct packed {
    pin_drive_t sclk;
    pin_drive_t serial_out_pin;
    pin_drive_t serial_in_pin;
    pin_drive_t ssel;
    pin_drive_t scl;
    pin_drive_t sda;
    logic       pins_owned;
  } pin_bundle_t;
endpackage : serial_pkg

// File: scl_debounce.sv
// Debounce filter for the two-wire bus clock, counted in system clocks.
`timescale 1ns/10ps
`include "serial_params.svh"
module scl_debounce (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] deb_sel,
  input  wire logic       line_in,
  output logic            line_out
);
  import serial_pkg::*;

  typedef struct packed {
    logic       filt;
    logic [2:0] cnt;
  } deb_state_t;

  deb_state_t st_r;
  deb_state_t st_nxt;
  logic [2:0] need;

  // Codes 00 none, 01 two clocks, 1x four clocks.
  always_comb
  begin
    need   = deb_sel[1] ? `DEB_FOUR : (deb_sel[0] ? `DEB_TWO : 3'h0);
    st_nxt = st_r;
    if (line_in == st_r.filt)
    begin
      st_nxt.cnt = 3'h0;
    end
    else if (st_r.cnt >= need)
    begin
      st_nxt.filt = line_in;
      st_nxt.cnt  = 3'h0;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 3'h1;
    end
  end

  // The filtered level only moves after the input has held steady.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      st_r <= '{filt: 1'b1, cnt: 3'h0};
    else
      st_r <= st_nxt;
  end

  assign line_out = st_r.filt;
endmodule : scl_debounce

// File: serial_if.sv
// Serial interface: SPI master or slave, or two-wire slave bus pins, with an APB register slave.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "serial_params.svh"
// Summary of operation
// - SPI uses select, clock, data in and data out; select only as slave with select enable set.
// - Select enable low leaves the select line undriven and ignored.
// - Enabled with select enable: data in floats, data out idles high.
// - Master drives clock at idle polarity; slave leaves clock floating.
// - Module enable low releases all pins to other functions.
// - Master makes the clock and starts when the data register is written.
// - Bits gather in a shift buffer; the byte is copied when complete.
// - Data write during a transfer is ignored and sets the collision flag.
// - Slave holds the loaded byte until select and clock edges arrive.
// - Two-wire lines are driven only as open-drain pull-downs.
// - Two-wire mode uses no chip select.
// - Two-wire side acts only as a slave.
// - Pin pull-up control keeps working in two-wire mode.
// - Two-wire clock is debounced by none, two or four system clocks.
// - One eight-bit data register carries every SPI byte; no two-wire byte reaches it.
// - Three-bit mode field: master codes, slave 101, two-wire 110, 111 unused.
// - Completion flag sets itself after a byte and is cleared by software.
// - Debounce field: 00 none, 01 two clocks, 1x four clocks.
// - Polarity bit high means idle clock low, low means idle high.
module serial_if (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   sclk_i,
  input  wire logic                   sdi_i,
  input  wire logic                   ssel_n_i,
  input  wire logic                   scl_i,
  input  wire logic                   sda_i,
  input  wire logic                   sub_clk_tick,
  input  wire logic                   timer_tick,
  input  wire logic                   pullup_ctrl,
  output serial_pkg::pin_bundle_t     pins,
  output logic                        scl_pullup_en,
  output logic                        sda_pullup_en,
  output logic                        deb_scl
);
  import serial_pkg::*;

  typedef struct packed {
    logic [7:0]  mode_ctrl;
    logic [7:0]  bus_status;
    logic [7:0]  data;
    logic [7:0]  own_addr;
    logic [7:0]  timeout_ctrl;
    logic [7:0]  spi_ctrl;
    logic [7:0]  shift;
    logic [3:0]  bit_cnt;
    logic [7:0]  div_cnt;
    logic        sclk_lvl;
    logic        tick_half;
    xfer_state_t xfer;
    logic [1:0]  sclk_s;
    logic [1:0]  sdi_s;
    logic [1:0]  ssel_s;
    logic [1:0]  scl_s;
    logic [1:0]  sub_s;
    logic        sclk_d;
    logic        sub_d;
    logic        in_bit;
    logic        sdo_bit;
    logic [31:0] rdata;
  } core_state_t;

  core_state_t st_r;
  core_state_t st_nxt;

  // Field views of the control registers.
  op_mode_t    mode;
  logic        mod_en;
  logic        sel_en;
  logic        msb_first;
  logic        polarity;
  logic        edge_sel;
  logic        is_master;
  logic        is_slave;
  logic        is_i2c;
  logic        wr_acc;
  logic        rd_acc;
  logic        addr_ok;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        sample_edge;
  logic        shift_edge;
  logic        master_tick;
  logic        sub_rise;
  logic        slave_sel;
  logic [7:0]  half_len;

  // Picks the bit that leaves first, by the chosen order.
  function automatic logic out_bit(input logic [7:0] v, input logic msb);
    out_bit = msb ? v[7] : v[0];
  endfunction : out_bit

  // Shifts one received bit into the buffer in the chosen order.
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b, input logic msb);
    shift_in = msb ? {v[6:0], b} : {b, v[7:1]};
  endfunction : shift_in

  // Address decode shared by the read and write paths.
  function automatic logic is_off(input logic [11:0] a, input logic [11:0] off);
    is_off = (a == off);
  endfunction : is_off

  ////////////////////////////////////////////////////////////////////////////
  // Control field decode.
  assign mode      = op_mode_t'(st_r.mode_ctrl[`MODE_MSB:`MODE_LSB]);
  assign mod_en    = st_r.mode_ctrl[`BIT_MOD_EN];
  assign sel_en    = st_r.spi_ctrl[`BIT_SEL_EN];
  assign msb_first = st_r.spi_ctrl[`BIT_ORDER];
  assign polarity  = st_r.spi_ctrl[`BIT_POLARITY];
  assign edge_sel  = st_r.spi_ctrl[`BIT_EDGE];
  assign is_master = (mode <= MODE_M_TIMER);
  assign is_slave  = (mode == MODE_SPI_SLV);
  assign is_i2c    = (mode == MODE_I2C_SLV);

  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && !penable && !pwrite;
  assign addr_ok = is_off(paddr, `OFF_MODE_CTRL) || is_off(paddr, `OFF_BUS_STATUS) ||
                   is_off(paddr, `OFF_DATA) || is_off(paddr, `OFF_OWN_ADDR) ||
                   is_off(paddr, `OFF_TIMEOUT_CTRL) || is_off(paddr, `OFF_SPI_CTRL_TWO);

  // Edges of the synchronised slave clock; the first stage is never read here.
  assign sclk_rise = st_r.sclk_s[1] && !st_r.sclk_d;
  assign sclk_fall = !st_r.sclk_s[1] && st_r.sclk_d;
  assign sub_rise  = st_r.sub_s[1] && !st_r.sub_d;
  // Capture edge: rising when polarity equals edge select, else falling.
  assign sample_edge = (polarity == edge_sel) ? sclk_rise : sclk_fall;
  assign shift_edge  = (polarity == edge_sel) ? sclk_fall : sclk_rise;
  // Select is honoured only when its enable is set.
  assign slave_sel = sel_en ? !st_r.ssel_s[1] : 1'b1;

  // Master half-period length by clock source.
  always_comb
  begin
    case (mode)
      MODE_M_DIV4:  half_len = `HALF_DIV4;
      MODE_M_DIV16: half_len = `HALF_DIV16;
      MODE_M_DIV64: half_len = `HALF_DIV64;
      default:      half_len = 8'h00;
    endcase
  end

  // External sources give one half period per tick; divided sources count up to the half length.
  always_comb
  begin
    case (mode)
      MODE_M_SUB:   master_tick = sub_rise;
      MODE_M_TIMER: master_tick = timer_tick;
      default:      master_tick = (st_r.div_cnt == half_len);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for registers, the shift engine and synchronisers.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.sclk_s = {st_r.sclk_s[0], sclk_i};
    st_nxt.sdi_s  = {st_r.sdi_s[0], sdi_i};
    st_nxt.ssel_s = {st_r.ssel_s[0], ssel_n_i};
    st_nxt.scl_s  = {st_r.scl_s[0], scl_i};
    st_nxt.sub_s  = {st_r.sub_s[0], sub_clk_tick};
    st_nxt.sclk_d = st_r.sclk_s[1];
    st_nxt.sub_d  = st_r.sub_s[1];
    st_nxt.div_cnt = (st_r.xfer == XFER_ACTIVE && !master_tick) ? st_r.div_cnt + 8'h01 : 8'h00;

    // Register writes take effect in the access phase.
    if (wr_acc)
    begin
      if (is_off(paddr, `OFF_MODE_CTRL))
        st_nxt.mode_ctrl = pwdata[7:0] & `MODE_CTRL_MASK;
      if (is_off(paddr, `OFF_BUS_STATUS))
        st_nxt.bus_status = (st_r.bus_status & ~`BUS_STATUS_WMASK) | (pwdata[7:0] & `BUS_STATUS_WMASK);
      if (is_off(paddr, `OFF_OWN_ADDR))
        st_nxt.own_addr = pwdata[7:0];
      if (is_off(paddr, `OFF_TIMEOUT_CTRL))
        st_nxt.timeout_ctrl = pwdata[7:0];
      if (is_off(paddr, `OFF_SPI_CTRL_TWO))
        st_nxt.spi_ctrl = pwdata[7:0];
      if (is_off(paddr, `OFF_DATA))
      begin
        if (st_r.xfer == XFER_ACTIVE)
        begin
          st_nxt.spi_ctrl[`BIT_WRITE_COLLISION_FLAG] = 1'b1;
        end
        else
        begin
          st_nxt.data = pwdata[7:0];
          st_nxt.shift = pwdata[7:0];
          st_nxt.bit_cnt = 4'h0;
          st_nxt.sdo_bit = out_bit(pwdata[7:0], msb_first);
          if (mod_en && is_master)
          begin
            st_nxt.xfer = XFER_ACTIVE;
            st_nxt.sclk_lvl = !polarity;
            st_nxt.tick_half = 1'b0;
          end
        end
      end
    end

    // Master engine: each tick toggles the clock; first half samples, second shifts.
    if (mod_en && is_master && st_r.xfer == XFER_ACTIVE && master_tick)
    begin
      st_nxt.sclk_lvl  = !st_r.sclk_lvl;
      st_nxt.tick_half = !st_r.tick_half;
      if (!st_r.tick_half)
      begin
        st_nxt.shift = shift_in(st_r.shift, st_r.sdi_s[1], msb_first);
        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
      end
      else if (st_r.bit_cnt == `BITS_PER_BYTE)
      begin
        st_nxt.xfer = XFER_DONE;
      end
      else
      begin
        st_nxt.sdo_bit = out_bit(st_r.shift, msb_first);
      end
    end

    // Slave engine: runs only on the remote master's clock while selected.
    if (mod_en && is_slave && slave_sel)
    begin
      if (sample_edge)
      begin
        st_nxt.shift = shift_in(st_r.shift, st_r.sdi_s[1], msb_first);
        st_nxt.bit_cnt = st_r.bit_cnt + 4'h1;
        st_nxt.xfer = XFER_ACTIVE;
        if (st_r.bit_cnt == `BITS_PER_BYTE - 4'h1)
          st_nxt.xfer = XFER_DONE;
      end
      else if (shift_edge && st_r.bit_cnt != 4'h0)
      begin
        st_nxt.sdo_bit = out_bit(st_r.shift, msb_first);
      end
    end

    // Select released early in slave mode: flag the incomplete byte.
    if (mod_en && is_slave && sel_en && st_r.ssel_s[1] && st_r.xfer == XFER_ACTIVE)
    begin
      st_nxt.xfer = XFER_IDLE;
      st_nxt.bit_cnt = 4'h0;
      st_nxt.mode_ctrl[`BIT_INCOMPLETE] = 1'b1;
      st_nxt.spi_ctrl[`BIT_TRF] = 1'b1;
    end

    // Completed byte is latched from the buffer; completion flag set wins over a clear.
    if (st_r.xfer == XFER_DONE)
    begin
      st_nxt.data = st_r.shift;
      st_nxt.spi_ctrl[`BIT_TRF] = 1'b1;
      st_nxt.xfer = XFER_IDLE;
      st_nxt.bit_cnt = 4'h0;
      st_nxt.sclk_lvl = !polarity;
    end

    // Disabling the module abandons any transfer in flight.
    if (!mod_en)
    begin
      st_nxt.xfer = XFER_IDLE;
      st_nxt.bit_cnt = 4'h0;
    end

    // Read data is captured in the setup phase so it stands through access.
    st_nxt.rdata = 32'h0000_0000;
    if (rd_acc)
    begin
      if (is_off(paddr, `OFF_MODE_CTRL))
        st_nxt.rdata = {24'h00_0000, st_r.mode_ctrl};
      if (is_off(paddr, `OFF_BUS_STATUS))
        st_nxt.rdata = {24'h00_0000, st_r.bus_status};
      if (is_off(paddr, `OFF_DATA))
        st_nxt.rdata = {24'h00_0000, st_r.data};
      if (is_off(paddr, `OFF_OWN_ADDR))
        st_nxt.rdata = {24'h00_0000, st_r.own_addr};
      if (is_off(paddr, `OFF_TIMEOUT_CTRL))
        st_nxt.rdata = {24'h00_0000, st_r.timeout_ctrl};
      if (is_off(paddr, `OFF_SPI_CTRL_TWO))
        st_nxt.rdata = {24'h00_0000, st_r.spi_ctrl};
    end
    else if (psel && penable)
    begin
      st_nxt.rdata = st_r.rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; every flop takes a constant under reset.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.mode_ctrl  <= `MODE_CTRL_RESET;
      st_r.bus_status <= `BUS_STATUS_RESET;
      st_r.spi_ctrl   <= `SPI_CTRL_RESET;
      st_r.sclk_lvl   <= 1'b1;
      st_r.sclk_s     <= 2'b00;
      st_r.ssel_s     <= 2'b11;
      st_r.scl_s      <= 2'b11;
      st_r.sdo_bit    <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-wire clock filter.
  scl_debounce u_scl_debounce (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .deb_sel  (st_r.mode_ctrl[`DEB_MSB:`DEB_LSB]),
    .line_in  (st_r.scl_s[1]),
    .line_out (deb_scl)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive. Unused in the two-wire data path: no address logic lives here.
  always_comb
  begin
    pins = '0;
    pins.pins_owned = mod_en && (is_master || is_slave || is_i2c);
    if (mod_en && (is_master || is_slave))
    begin
      pins.serial_out_pin.oe = 1'b1;
      pins.serial_out_pin.o  = (st_r.xfer == XFER_IDLE && !(is_slave && slave_sel)) ? 1'b1 : st_r.sdo_bit;
      pins.serial_in_pin.oe = 1'b0;
      pins.ssel.oe = 1'b0;
      if (is_master)
      begin
        pins.sclk.oe = 1'b1;
        pins.sclk.o  = (st_r.xfer == XFER_IDLE) ? !polarity : st_r.sclk_lvl;
      end
    end
    // Open-drain only: output value is always low, enable pulls the line. No select used.
    pins.scl.o  = 1'b0;
    pins.sda.o  = 1'b0;
    pins.scl.oe = 1'b0;
    pins.sda.oe = 1'b0;
  end

  // Pull-ups follow their own control whatever the mode.
  assign scl_pullup_en = pullup_ctrl;
  assign sda_pullup_en = pullup_ctrl;

  // Bus answers: zero wait states, unmapped addresses get an error.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = st_r.rdata;
endmodule : serial_if

// File: serial_if_props.sv
// Checker of pin, debounce and pull-up behaviour at the serial interface ports.
`timescale 1ns/10ps
module serial_if_props (
  input wire logic                    core_clk,
  input wire logic                    rst_n,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [11:0]             paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    pready,
  input wire logic                    scl_i,
  input wire logic                    pullup_ctrl,
  input wire serial_pkg::pin_bundle_t pins,
  input wire logic                    scl_pullup_en,
  input wire logic                    sda_pullup_en,
  input wire logic                    deb_scl
);
  import serial_pkg::*;
  logic [7:0] mode_r;
  logic [7:0] spi_r;
  logic       mst;
  logic       two;
  // Shadow copies of the control bytes, so that pin rules can be judged by mode.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_r <= 8'hE0;
      spi_r  <= 8'h00;
    end
    else if (psel && penable && pwrite && pready)
    begin
      if (paddr == 12'h000) mode_r <= pwdata[7:0];
      if (paddr == 12'h014) spi_r <= pwdata[7:0];
    end
  end
  // Mode decode of the shadow copy.
  assign mst = mode_r[1] && (mode_r[7:5] <= 3'h4);
  assign two = mode_r[1] && (mode_r[7:5] == 3'h6);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence scl_steady;
    $stable(scl_i) [*8];
  endsequence
  chk_pullup_follow: assert property (scl_pullup_en == pullup_ctrl && sda_pullup_en == pullup_ctrl)
    else $error("pull-up enables do not follow their control");
  chk_open_drain: assert property (!(pins.scl.oe && pins.scl.o) && !(pins.sda.oe && pins.sda.o))
    else $error("two-wire line driven high");
  chk_pins_freed: assert property (!mode_r[1] |-> !pins.pins_owned && !pins.sclk.oe && !pins.serial_out_pin.oe)
    else $error("pins kept while disabled");
  chk_sel_float: assert property (!spi_r[2] || two |-> !pins.ssel.oe)
    else $error("select line driven");
  chk_sdi_float: assert property (mode_r[1] && spi_r[2] |-> !pins.serial_in_pin.oe)
    else $error("data input driven");
  chk_slave_clock: assert property (mode_r[1] && mode_r[7:5] == 3'h5 |-> !pins.sclk.oe)
    else $error("slave drives clock line");
  chk_idle_level: assert property ($rose(mode_r[1]) && mst |-> pins.sclk.oe && pins.sclk.o == !spi_r[5])
    else $error("master clock not at idle level");
  chk_sdo_idle: assert property ($rose(mode_r[1]) && mode_r[7:5] <= 3'h5 && spi_r[2] |-> pins.serial_out_pin.o)
    else $error("data output not idle high");
  chk_deb_settle: assert property (scl_steady ##0 two |-> deb_scl == scl_i)
    else $error("filtered clock does not settle");
  chk_glitch_stop: assert property (scl_steady ##0 (two && mode_r[3:2] != 2'b00) ##1 $changed(scl_i) ##1 $changed(scl_i)
    |=> $stable(deb_scl) [*6])
    else $error("single-cycle glitch passed the filter");
endmodule : serial_if_props

bind serial_if serial_if_props u_props (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .scl_i(scl_i), .pullup_ctrl(pullup_ctrl),
  .pins(pins), .scl_pullup_en(scl_pullup_en), .sda_pullup_en(sda_pullup_en), .deb_scl(deb_scl));

// File: spi_far_end.sv
// Remote SPI party: slave to the block's clock, or master with a 320 ns clock.
`timescale 1ns/10ps
module spi_far_end (
  input  wire logic       clk_seen,
  input  wire logic       sdo_pin,
  output logic            sclk_i,
  output logic            sdi_i,
  output logic            ssel_n_i,
  output logic [7:0]      rx_byte,
  output int              edges
);
  logic [7:0] tx_r = 8'h00;
  logic       msb_r = 1'b1;
  int         idx = 0;
  // Idle levels: clock low for polarity one, select released.
  initial
  begin
    sclk_i = 1'b0;
    sdi_i = 1'b1;
    ssel_n_i = 1'b1;
    rx_byte = 8'h00;
    edges = 0;
  end
  // Loads the reply and shows its first bit before any clock edge.
  task arm(input logic [7:0] b, input logic m);
    tx_r = b;
    msb_r = m;
    idx = 0;
    edges = 0;
    sdi_i = m ? b[7] : b[0];
  endtask : arm
  // Captures one bit; the order must match the block's setting.
  task take();
    edges++;
    rx_byte = msb_r ? {rx_byte[6:0], sdo_pin} : {sdo_pin, rx_byte[7:1]};
  endtask : take
  // Moves to the next bit; after the last one the line shows no stale value.
  task step();
    idx++;
    sdi_i = (idx < 8) ? (msb_r ? tx_r[7 - idx] : tx_r[idx]) : ~sdi_i;
  endtask : step
  // Capture on the rising edge, shift on the falling edge.
  always @(posedge clk_seen) take();
  always @(negedge clk_seen) step();
  // Master role: select first, then eight clocks, then release.
  task run(input logic [7:0] b, input logic m);
    arm(b, m);
    #13 ssel_n_i = 1'b0;
    #320;
    repeat (8)
    begin
      #160 sclk_i = 1'b1;
      take();
      #160 sclk_i = 1'b0;
      step();
    end
    #160 ssel_n_i = 1'b1;
  endtask : run
endmodule : spi_far_end

// File: testbench.sv
// Self-checking bench for the serial interface.
`timescale 1ns/10ps
`include "serial_params.svh"
module testbench;
  import serial_pkg::*;
  logic        core_clk = 0;
  logic        rst_n = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic        scl_i = 1;
  logic        pullup_ctrl = 0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sclk_i;
  logic        sdi_i;
  logic        ssel_n_i;
  logic        scl_pullup_en;
  logic        sda_pullup_en;
  logic        deb_scl;
  logic [7:0]  rx_byte;
  logic [31:0] rv;
  logic        rerr;
  int          edges;
  int          error_cnt = 0;
  int          checked = 0;
  pin_bundle_t pins;
  serial_if u_serial_if (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sclk_i(sclk_i),
    .sdi_i(sdi_i), .ssel_n_i(ssel_n_i), .scl_i(scl_i), .sda_i(1'b1), .sub_clk_tick(1'b0), .timer_tick(1'b0),
    .pullup_ctrl(pullup_ctrl), .pins(pins), .scl_pullup_en(scl_pullup_en), .sda_pullup_en(sda_pullup_en),
    .deb_scl(deb_scl));
  spi_far_end u_far (.clk_seen(pins.sclk.oe & pins.sclk.o), .sdo_pin(pins.serial_out_pin.o), .sclk_i(sclk_i),
    .sdi_i(sdi_i), .ssel_n_i(ssel_n_i), .rx_byte(rx_byte), .edges(edges));
  always #20 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task check(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task close_out();
    if (error_cnt == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  // One APB transfer; an edge passes first so that no signal is set twice in a step.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rv = prdata;
    rerr = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 20)
    begin
      error_cnt++;
      close_out();
    end
  endtask : apb
  // Polls the completion flag under a bound.
  task wait_trf();
    int n;
    n = 0;
    rv = 0;
    while (rv[0] !== 1'b1 && n < 400)
    begin
      apb(0, `OFF_SPI_CTRL_TWO, 0);
      n++;
    end
    check("trf", rv[0], 1);
    if (rv[0] !== 1'b1) close_out();
  endtask : wait_trf
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset();
    apb(0, `OFF_MODE_CTRL, 0);
    check("mode_rst", rv, 32'h000000E0);
    apb(0, `OFF_BUS_STATUS, 0);
    check("bus_rst", rv, 32'h00000081);
    apb(0, 12'h018, 0);
    check("unmapped", rerr, 1);
    for (int c = 0; c < 8; c++)
    begin
      apb(1, `OFF_MODE_CTRL, c << 5);
      apb(0, `OFF_MODE_CTRL, 0);
      check("mode_code", rv, c << 5);
    end
  endtask : t_reset
  task t_master(input op_mode_t m, input logic [7:0] tx, input logic [7:0] rem, input logic msb);
    u_far.arm(rem, msb);
    apb(1, `OFF_MODE_CTRL, {m, 5'h00});
    apb(1, `OFF_SPI_CTRL_TWO, 32'h34 | (msb << 3));
    apb(1, `OFF_MODE_CTRL, {m, 5'h02});
    apb(1, `OFF_DATA, tx);
    apb(1, `OFF_DATA, ~tx);
    apb(0, `OFF_SPI_CTRL_TWO, 0);
    check("write_collision_flag", rv[1:0], 2'b10);
    wait_trf();
    check("edges", edges, 8);
    check("far_rx", rx_byte, tx);
    check("sclk_idle", pins.sclk.o, 0);
    apb(0, `OFF_DATA, 0);
    check("data_rx", rv, rem);
    apb(1, `OFF_SPI_CTRL_TWO, 32'h34 | (msb << 3));
    apb(0, `OFF_SPI_CTRL_TWO, 0);
    check("flags_clr", rv[1:0], 0);
  endtask : t_master
  task t_slave();
    apb(1, `OFF_MODE_CTRL, 32'hA0);
    apb(1, `OFF_SPI_CTRL_TWO, 32'h3C);
    apb(1, `OFF_MODE_CTRL, 32'hA2);
    apb(1, `OFF_DATA, 32'h5A);
    u_far.run(8'h3C, 1);
    wait_trf();
    check("slv_tx", rx_byte, 8'h5A);
    apb(0, `OFF_DATA, 0);
    check("slv_rx", rv, 32'h3C);
    apb(1, `OFF_MODE_CTRL, 32'hA0);
    @(negedge core_clk);
    check("freed", {pins.sclk.oe, pins.serial_out_pin.oe, pins.pins_owned}, 0);
  endtask : t_slave
  // Pulses of one, three and six cycles against each filter code.
  task t_two();
    int w[3] = '{1, 3, 6};
    int need;
    logic seen;
    for (int c = 0; c < 4; c++)
    begin
      apb(1, `OFF_MODE_CTRL, 32'hC2 | (c << 2));
      need = (c == 0) ? 0 : (c == 1) ? 2 : 4;
      for (int k = 0; k < 3; k++)
      begin
        repeat (12) @(posedge core_clk);
        scl_i <= 0;
        repeat (w[k]) @(posedge core_clk);
        scl_i <= 1;
        seen = 0;
        repeat (12)
        begin
          @(negedge core_clk);
          if (deb_scl !== 1'b1) seen = 1;
        end
        check("debounce", seen, w[k] > need);
      end
    end
    @(posedge core_clk);
    pullup_ctrl <= 1;
    @(negedge core_clk);
    check("pullup", {scl_pullup_en, sda_pullup_en, pins.scl.oe}, 3'b110);
  endtask : t_two
  ////////////////////////////////////////////////////////////////////////////////
  // Reset for twelve cycles, then the scenarios in turn.
  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1;
    t_reset();
    t_master(MODE_M_DIV16, 8'hA5, 8'h3C, 1);
    t_master(MODE_M_DIV64, 8'h81, 8'h5A, 0);
    t_slave();
    t_two();
    close_out();
  end
endmodule : testbench
